// ---- src/rado_top.sv ----
// Output stage: two 16-bit analog channels and sixteen open-collector lines.
// Assumes APB master on clk_sys; measured velocity and position come from
// counter logic on the same clock.
`timescale 1ns/1ps
`include "rado_params.svh"
module rado_top
(
	input  wire logic               clk_sys,
	input  wire logic               rst_n,
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [7:0]         paddr,
	input  wire logic [31:0]        pwdata,
	input  wire logic [3:0]         pstrb,
	output logic [31:0]             prdata,
	output logic                    pready,
	output logic                    pslverr,
	input  wire logic signed [23:0] meas_vel,
	input  wire logic signed [23:0] meas_pos,
	output rado_pkg::rado_aout_t    aout,
	output rado_pkg::rado_pins_t    dout_pins,
	output logic                    track_active
);
	import rado_pkg::*;

	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic logic [31:0] wr_merge(input logic [31:0] cur,
		input logic [31:0] wd, input logic [3:0] strb);
		logic [31:0] res;
		res = cur;
		for (int b = 0; b < 4; b++)
		begin
			if (strb[b])
				res[b*8 +: 8] = wd[b*8 +: 8];
		end
		return res;
	endfunction

	// Unused code 2'b10 falls back to fixed so a channel never runs wild
	function automatic rado_mode_t mode_decode(input logic [1:0] code);
		rado_mode_t m;
		m = RADO_FIXED;
		if (code == RADO_VEL)
			m = RADO_VEL;
		else if (code == RADO_POS)
			m = RADO_POS;
		return m;
	endfunction

	// ****************************************************************
	// Reset release
	// ****************************************************************
	logic rst_meta;
	logic rst_sync_n;

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rst_meta   <= 1'b0;
			rst_sync_n <= 1'b0;
		end
		else
		begin
			rst_meta   <= 1'b1;
			rst_sync_n <= rst_meta;
		end
	end

	// ****************************************************************
	// APB decode
	// ****************************************************************
	logic [15:0]        dout;
	logic [15:0]        pend_mask;
	logic [15:0]        pend_val;
	logic signed [15:0] fixed_stg [2];
	logic [31:0]        volt_stg;
	logic [23:0]        tgt_stg;
	logic [3:0]         fire;
	rado_chan_t         cfg [2];
	logic [1:0]         div_busy;
	logic [31:0]        rd_mux;

	wire aligned   = (paddr[1:0] == 2'b00);
	wire hit_word  = aligned && paddr == `RADO_OFF_DOUT_WORD;
	wire hit_line  = aligned && paddr == `RADO_OFF_DOUT_LINE;
	wire hit_fix0  = aligned && paddr == `RADO_OFF_FIXED0;
	wire hit_fix1  = aligned && paddr == `RADO_OFF_FIXED1;
	wire hit_apply = aligned && paddr == `RADO_OFF_FIXED_APPLY;
	wire hit_volt  = aligned && paddr == `RADO_OFF_TRK_VOLT;
	wire hit_tgt   = aligned && paddr == `RADO_OFF_TRK_TARGET;
	wire hit_cfg   = aligned && paddr == `RADO_OFF_TRK_CFG;
	wire hit_fire  = aligned && paddr == `RADO_OFF_FIRE;
	wire hit_aout  = aligned && paddr == `RADO_OFF_AOUT;
	wire hit_stat  = aligned && paddr == `RADO_OFF_STATUS;
	wire hit_any   = hit_word | hit_line | hit_fix0 | hit_fix1 | hit_apply
		| hit_volt | hit_tgt | hit_cfg | hit_fire | hit_aout | hit_stat;

	wire access = psel && penable;
	wire wr     = access && pwrite && hit_any;
	wire setup  = psel && !penable;

	// Single-cycle access phase, no wait states
	assign pready  = 1'b1;
	assign pslverr = access && !hit_any;

	// Command registers merge onto zero: they hold no state of their own
	wire [31:0] cmd_wd = wr_merge(32'h0, pwdata, pstrb);

	// ****************************************************************
	// Digital line commands
	// ****************************************************************
	wire [3:0]  ln_idx    = cmd_wd[3:0];
	wire        ln_state  = cmd_wd[`RADO_LINE_STATE_BIT];
	wire        ln_commit = cmd_wd[`RADO_LINE_COMMIT_BIT];
	wire [15:0] ln_hot    = 16'h0001 << ln_idx;
	wire [15:0] ln_mask   = pend_mask | ln_hot;
	wire [15:0] ln_val    = (pend_val & ~ln_hot) | (ln_state ? ln_hot : 16'h0000);
	// All staged pairs land in one edge
	wire [15:0] ln_dout   = (dout & ~ln_mask) | (ln_val & ln_mask);
	wire [31:0] word_m    = wr_merge({16'h0000, dout}, pwdata, pstrb);
	wire [15:0] word_dout = word_m[15:0];

	always_ff @(posedge clk_sys or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			dout      <= `RADO_RST_DOUT;
			pend_mask <= 16'h0000;
			pend_val  <= 16'h0000;
		end
		else if (wr && hit_word)
			dout <= word_dout;
		else if (wr && hit_line && ln_commit)
		begin
			dout      <= ln_dout;
			pend_mask <= 16'h0000;
			pend_val  <= 16'h0000;
		end
		else if (wr && hit_line)
		begin
			pend_mask <= ln_mask;
			pend_val  <= ln_val;
		end
	end

	// Open collector: a 1 sinks the pin, a 0 floats it
	assign dout_pins.out = 16'h0000;
	assign dout_pins.oe  = dout;

	// ****************************************************************
	// Staging and configuration registers
	// ****************************************************************
	wire [1:0] apply_ch = (wr && hit_apply) ? cmd_wd[1:0] : 2'b00;
	wire       cfg_ch   = cmd_wd[`RADO_CFG_CHAN_BIT];
	// Merged words first, since a call result cannot be sliced in place
	wire [31:0] fix0_m  = wr_merge({16'h0000, fixed_stg[0]}, pwdata, pstrb);
	wire [31:0] fix1_m  = wr_merge({16'h0000, fixed_stg[1]}, pwdata, pstrb);
	wire [31:0] tgt_m   = wr_merge({8'h00, tgt_stg}, pwdata, pstrb);
	wire [31:0] fire_m  = wr_merge({28'h0, fire}, pwdata, pstrb);

	always_ff @(posedge clk_sys or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			fixed_stg[0] <= `RADO_RST_AOUT;
			fixed_stg[1] <= `RADO_RST_AOUT;
			volt_stg     <= 32'h0000_0000;
			tgt_stg      <= `RADO_RST_TARGET;
			fire         <= 4'h0;
			for (int c = 0; c < 2; c++)
				cfg[c] <= '{RADO_FIXED, `RADO_RST_AOUT, `RADO_RST_AOUT,
					`RADO_RST_TARGET};
		end
		else
		begin
			// Full 16-bit code spans -10 V to +10 V
			if (wr && hit_fix0)
				fixed_stg[0] <= fix0_m[15:0];
			if (wr && hit_fix1)
				fixed_stg[1] <= fix1_m[15:0];
			if (wr && hit_volt)
				volt_stg <= wr_merge(volt_stg, pwdata, pstrb);
			if (wr && hit_tgt)
				tgt_stg <= tgt_m[23:0];
			if (wr && hit_fire)
				fire <= fire_m[3:0];
			if (wr && hit_cfg)
				cfg[cfg_ch] <= '{mode_decode(cmd_wd[1:0]), volt_stg[15:0],
					volt_stg[31:16], tgt_stg};
			// A fixed setting ends tracking on that channel
			for (int c = 0; c < 2; c++)
			begin
				if (apply_ch[c])
					cfg[c].mode <= RADO_FIXED;
			end
		end
	end

	// ****************************************************************
	// Firing activation
	// ****************************************************************
	logic              trk_q;
	logic signed [23:0] pos_origin;

	// is the host's job; the pulse-defined bit stands for it
	assign track_active = fire[`RADO_FIRE_PULSE_BIT]
		&& fire[2:0] >= `RADO_FIRE_MODE_MIN
		&& fire[2:0] <= `RADO_FIRE_MODE_MAX;

	always_ff @(posedge clk_sys or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			trk_q      <= 1'b0;
			pos_origin <= 24'sh000000;
		end
		else
		begin
			trk_q <= track_active;
			// Zero point of the position ramp, taken as firing starts
			if (track_active && !trk_q)
				pos_origin <= meas_pos;
		end
	end

	// ****************************************************************
	// Tracking channels
	// ****************************************************************
	logic signed [15:0] aout_q [2];

	for (genvar ch = 0; ch < 2; ch++)
	begin : g_chan
		// One edge late, so the first division already sees the new origin
		wire tracking = track_active && trk_q && cfg[ch].mode != RADO_FIXED;

		// Whole steps only: no fraction is carried anywhere
		wire signed [25:0] vel_ext = 26'(meas_vel);
		wire signed [25:0] pos_rel = 26'(meas_pos) - 26'(pos_origin);
		wire signed [25:0] meas    = (cfg[ch].mode == RADO_POS) ? pos_rel
			: vel_ext;
		wire               t_neg   = cfg[ch].target[23];
		wire signed [25:0] tgt_ext = 26'(cfg[ch].target);
		wire signed [25:0] n_dir   = t_neg ? -meas : meas;
		wire signed [25:0] t_mag   = t_neg ? -tgt_ext : tgt_ext;
		// Past the target the count saturates, pinning the ceiling
		wire [23:0] n_clamp = n_dir[25] ? 24'h000000
			: (n_dir > t_mag) ? t_mag[23:0] : n_dir[23:0];
		wire signed [16:0] span = 17'(cfg[ch].ceil_v) - 17'(cfg[ch].floor_v);
		wire [15:0] span_mag = span[16] ? 16'(-span) : span[15:0];
		wire [39:0] prod     = 40'(n_clamp) * 40'(span_mag);
		wire        t_zero   = (t_mag == 26'sd0);
		wire        d_done;
		wire [15:0] d_quo;
		// Quotient is n*span/target: a multiple of span/target per step
		wire signed [16:0] ramp = span[16] ? 17'(cfg[ch].floor_v) - 17'(d_quo)
			: 17'(cfg[ch].floor_v) + 17'(d_quo);
		wire d_start = tracking && !t_zero && !div_busy[ch] && !d_done;

		rado_ramp_div #(
			.NW (24),
			.QW (16)
		) u_div (
			.clk_sys    (clk_sys),
			.rst_sync_n (rst_sync_n),
			.start      (d_start),
			.num        (prod),
			.den        (t_mag[23:0]),
			.busy       (div_busy[ch]),
			.done       (d_done),
			.quo        (d_quo)
		);

		// Value holds between commands and updates
		always_ff @(posedge clk_sys or negedge rst_sync_n)
		begin
			if (!rst_sync_n)
				aout_q[ch] <= `RADO_RST_AOUT;
			else if (apply_ch[ch])
				aout_q[ch] <= fixed_stg[ch];
			else if (tracking && d_done)
				aout_q[ch] <= ramp[15:0];
			else if (tracking && t_zero)
				aout_q[ch] <= cfg[ch].ceil_v;
		end
	end

	assign aout.first  = aout_q[0];
	assign aout.second = aout_q[1];

	// ****************************************************************
	// Read data
	// ****************************************************************
	// Unmapped addresses read as zero
	assign rd_mux = hit_word ? {16'h0000, dout}
		: hit_line ? {pend_val, pend_mask}
		: hit_fix0 ? {16'h0000, fixed_stg[0]}
		: hit_fix1 ? {16'h0000, fixed_stg[1]}
		: hit_volt ? volt_stg
		: hit_tgt  ? {8'h00, tgt_stg}
		: hit_cfg  ? {28'h0, cfg[1].mode, cfg[0].mode}
		: hit_fire ? {28'h0, fire}
		: hit_aout ? {aout_q[1], aout_q[0]}
		: hit_stat ? {29'h0, div_busy, track_active}
		: 32'h0000_0000;

	// Sampled in setup so it stands through the access phase
	always_ff @(posedge clk_sys or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			prdata <= 32'h0000_0000;
		else if (setup)
			prdata <= rd_mux;
	end

endmodule

// ---- src/rado_params.svh ----
// Constants of the ramped analog and digital output stage.
// Assumes an APB slave with byte addresses on an 8-bit paddr.
`ifndef RADO_PARAMS_SVH
`define RADO_PARAMS_SVH

// ********************************************************************
// Register byte offsets
// ********************************************************************
`define RADO_OFF_DOUT_WORD   8'h00
`define RADO_OFF_DOUT_LINE   8'h04
`define RADO_OFF_FIXED0      8'h08
`define RADO_OFF_FIXED1      8'h0c
`define RADO_OFF_FIXED_APPLY 8'h10
`define RADO_OFF_TRK_VOLT    8'h14
`define RADO_OFF_TRK_TARGET  8'h18
`define RADO_OFF_TRK_CFG     8'h1c
`define RADO_OFF_FIRE        8'h20
`define RADO_OFF_AOUT        8'h24
`define RADO_OFF_STATUS      8'h28

// ********************************************************************
// Field positions
// ********************************************************************
`define RADO_LINE_STATE_BIT  4
`define RADO_LINE_COMMIT_BIT 5
`define RADO_CFG_CHAN_BIT    2
`define RADO_FIRE_PULSE_BIT  3
`define RADO_FIRE_MODE_MIN   3'h3
`define RADO_FIRE_MODE_MAX   3'h5

// ********************************************************************
// Reset values
// ********************************************************************
`define RADO_RST_DOUT        16'h0000
`define RADO_RST_AOUT        16'h0000
`define RADO_RST_TARGET      24'h000001

`endif

// ---- src/rado_pkg.sv ----
// Types of the ramped analog and digital output stage.
// Assumes the constants header is included by the design files.
package rado_pkg;

	// Channel modes: fixed, velocity tracking, position tracking
	typedef enum logic [1:0]
	{
		RADO_FIXED = 2'b00,
		RADO_VEL   = 2'b01,
		RADO_POS   = 2'b11
	} rado_mode_t;

	typedef enum logic
	{
		RADO_IDLE = 1'b0,
		RADO_RUN  = 1'b1
	} rado_div_state_t;

	typedef struct packed
	{
		rado_mode_t         mode;
		logic signed [15:0] floor_v;
		logic signed [15:0] ceil_v;
		logic signed [23:0] target;
	} rado_chan_t;

	// Open-collector lines: oe high means pin pulled to ground
	typedef struct packed
	{
		logic [15:0] out;
		logic [15:0] oe;
	} rado_pins_t;

	typedef struct packed
	{
		logic signed [15:0] second;
		logic signed [15:0] first;
	} rado_aout_t;

endpackage

// ---- src/rado_ramp_div.sv ----
// Serial restoring divider for the tracking ramp, one quotient bit a cycle.
// Assumes a nonzero divisor; the caller holds start only while idle.
`timescale 1ns/1ps
module rado_ramp_div
#(
	parameter int NW = 24,
	parameter int QW = 16
)
(
	input  wire logic            clk_sys,
	input  wire logic            rst_sync_n,
	input  wire logic            start,
	input  wire logic [NW+QW-1:0] num,
	input  wire logic [NW-1:0]   den,
	output logic                 busy,
	output logic                 done,
	output logic [QW-1:0]        quo
);
	import rado_pkg::*;

	localparam int PW = NW + QW;
	localparam int CW = $clog2(PW + 1);

	rado_div_state_t state;
	logic [NW:0]     rem;
	logic [PW-1:0]   acc;
	logic [CW-1:0]   cnt;

	wire [NW:0] rem_sh = {rem[NW-1:0], acc[PW-1]};
	wire        take   = rem_sh >= {1'b0, den};
	wire [NW:0] rem_nx = take ? rem_sh - {1'b0, den} : rem_sh;

	assign busy = (state == RADO_RUN);

	always_ff @(posedge clk_sys or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			state <= RADO_IDLE;
			rem   <= '0;
			acc   <= '0;
			cnt   <= '0;
			done  <= 1'b0;
			quo   <= '0;
		end
		else
		begin
			done <= 1'b0;
			unique case (state)
				RADO_IDLE:
				begin
					if (start)
					begin
						acc   <= num;
						rem   <= '0;
						cnt   <= CW'(PW);
						state <= RADO_RUN;
					end
				end
				RADO_RUN:
				begin
					rem <= rem_nx;
					acc <= {acc[PW-2:0], take};
					cnt <= cnt - 1'b1;
					if (cnt == CW'(1))
					begin
						state <= RADO_IDLE;
						done  <= 1'b1;
						quo   <= {acc[QW-2:0], take};
					end
				end
			endcase
		end
	end

endmodule

// ---- sim/rado_props.sv ----
// Checker of the output stage, watching the top ports only.
// Assumes full-word APB writes; bound at the foot of this file.
`timescale 1ns/1ps
module rado_props
(
	input  wire logic                 clk_sys,
	input  wire logic                 rst_n,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [7:0]           paddr,
	input  wire logic [31:0]          pwdata,
	input  wire logic [3:0]           pstrb,
	input  wire rado_pkg::rado_aout_t aout,
	input  wire rado_pkg::rado_pins_t dout_pins,
	input  wire logic                 track_active
);
	import rado_pkg::*;
	logic [15:0] sh0;
	logic [15:0] sh1;
	logic [5:0]  idle;
	wire         acc_w = psel && penable && pwrite && pstrb == 4'hf;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// Shadows of staged fixed codes, since the design's copies are hidden
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sh0  <= 16'h0000;
			sh1  <= 16'h0000;
			idle <= 6'h00;
		end
		else
		begin
			if (acc_w && paddr == 8'h08) sh0 <= pwdata[15:0];
			if (acc_w && paddr == 8'h0c) sh1 <= pwdata[15:0];
			idle <= track_active ? 6'h00 : (idle == 6'h3f ? idle : idle + 6'h01);
		end
	end
	sequence s_wr(logic [7:0] a);
		acc_w && paddr == a;
	endsequence
	property p_oc_low;
		dout_pins.out == 16'h0000;
	endproperty
	property p_reset_float;
		disable iff (1'b0) !rst_n |-> dout_pins.oe == 16'h0000;
	endproperty
	property p_word;
		s_wr(8'h00) |=> dout_pins.oe == $past(pwdata[15:0]);
	endproperty
	property p_stage;
		s_wr(8'h04) ##0 !pwdata[5] |=> $stable(dout_pins.oe);
	endproperty
	property p_commit;
		s_wr(8'h04) ##0 pwdata[5] |=> dout_pins.oe[$past(pwdata[3:0])] == $past(pwdata[4]);
	endproperty
	property p_apply0;
		s_wr(8'h10) ##0 pwdata[0] |=> aout.first == sh0;
	endproperty
	property p_apply1;
		s_wr(8'h10) ##0 pwdata[1] |=> aout.second == sh1;
	endproperty
	property p_track_rise;
		$rose(track_active) |-> $past(acc_w && paddr == 8'h20 && pwdata[3]
			&& pwdata[2:0] >= 3'h3 && pwdata[2:0] <= 3'h5);
	endproperty
	// Divider may still finish a division after firing stops, but aout no longer takes it; the idle wait is margin
	property p_hold;
		idle == 6'h3f && !(acc_w && paddr == 8'h10) |=> $stable(aout);
	endproperty
	a_oc_low:      assert property (p_oc_low) else $error("line output not open");
	a_reset_float: assert property (p_reset_float) else $error("line driven in reset");
	a_word:        assert property (p_word) else $error("group load wrong");
	a_stage:       assert property (p_stage) else $error("staged pair applied");
	a_commit:      assert property (p_commit) else $error("line commit wrong");
	a_apply0:      assert property (p_apply0) else $error("first channel code wrong");
	a_apply1:      assert property (p_apply1) else $error("second channel code wrong");
	a_track_rise:  assert property (p_track_rise) else $error("tracking started early");
	a_hold:        assert property (p_hold) else $error("analog output drifted");
endmodule

bind rado_top rado_props chk_u
(
	.clk_sys      (clk_sys),
	.rst_n        (rst_n),
	.psel         (psel),
	.penable      (penable),
	.pwrite       (pwrite),
	.paddr        (paddr),
	.pwdata       (pwdata),
	.pstrb        (pstrb),
	.aout         (aout),
	.dout_pins    (dout_pins),
	.track_active (track_active)
);

// ---- sim/rado_host_model.sv ----
// Host controller model: APB master issuing output commands.
// Assumes one clock; a late pready is waited for, the bench bounds it.
`timescale 1ns/1ps
module rado_host_model
(
	input  wire logic        clk_sys,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [7:0]       paddr,
	output logic [31:0]      pwdata,
	output logic [3:0]       pstrb,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	initial
	begin
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 8'h00;
		pwdata  = 32'h0;
		pstrb   = 4'hf;
	end
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err);
		@(posedge clk_sys);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do
			@(posedge clk_sys);
		while (pready !== 1'b1);
		rd  = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		// Released bus shows no stale request
		paddr  <= ~a;
		pwdata <= ~d;
	endtask
	// Pulse-defined bit always set in the same write as the mode
	task automatic fire(input logic [2:0] mode);
		logic [31:0] rd;
		logic        err;
		xfer(1'b1, 8'h20, {28'h0, 1'b1, mode}, rd, err);
	endtask
endmodule

// ---- sim/rado_top_tb.sv ----
// Self-checking bench of the output stage.
// Assumes the host model as bus master and 42-cycle tracking updates.
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
	$display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module rado_top_tb;
	import rado_pkg::*;
	logic               clk_sys = 1'b0;
	logic               rst_n = 1'b1;
	logic               psel;
	logic               penable;
	logic               pwrite;
	logic [7:0]         paddr;
	logic [31:0]        pwdata;
	logic [3:0]         pstrb;
	logic [31:0]        prdata;
	logic               pready;
	logic               pslverr;
	logic signed [23:0] meas_vel = 24'sd0;
	logic signed [23:0] meas_pos = 24'sd0;
	rado_aout_t         aout;
	rado_pins_t         dout_pins;
	logic               track_active;
	int                 n_mismatch = 0;
	int                 n_compared = 0;
	int                 cycles = 0;
	always #5 clk_sys = ~clk_sys;
	rado_host_model host_u (.clk_sys(clk_sys), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr));
	rado_top dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .meas_vel(meas_vel),
		.meas_pos(meas_pos), .aout(aout), .dout_pins(dout_pins),
		.track_active(track_active));
	task automatic end_of_test;
		$display("mismatches %0d of %0d compared", n_mismatch, n_compared);
		if (n_mismatch == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	always @(posedge clk_sys)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			n_mismatch++;
			end_of_test;
		end
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] rd;
		logic        e;
		host_u.xfer(1'b1, a, d, rd, e);
		@(negedge clk_sys);
	endtask
	// Fixed waits: two 42-cycle update periods and margin
	task automatic settle;
		repeat (100) @(posedge clk_sys);
		@(negedge clk_sys);
	endtask
	task automatic do_reset;
		@(posedge clk_sys) rst_n <= 1'b0;
		repeat (10) @(posedge clk_sys);
		@(negedge clk_sys);
		`CHK(dout_pins.oe, 16'h0000)
		@(posedge clk_sys) rst_n <= 1'b1;
		repeat (3) @(posedge clk_sys);
	endtask
	task automatic t_group;
		logic [31:0] d;
		logic        e;
		wr(8'h00, 32'h93ad);
		`CHK(dout_pins.oe, 16'h93ad)
		`CHK(dout_pins.out, 16'h0000)
		host_u.xfer(1'b0, 8'h00, 32'h0, d, e);
		`CHK(d[15:0], 16'h93ad)
		host_u.xfer(1'b0, 8'h40, 32'h0, d, e);
		`CHK(e, 1'b1)
		`CHK(d, 32'h0)
	endtask
	task automatic t_lines;
		wr(8'h00, 32'h0);
		wr(8'h04, 32'h13);
		wr(8'h04, 32'h1f);
		`CHK(dout_pins.oe, 16'h0000)
		wr(8'h04, 32'h30);
		`CHK(dout_pins.oe, 16'h8009)
		wr(8'h04, 32'h2f);
		`CHK(dout_pins.oe, 16'h0009)
	endtask
	task automatic t_fixed;
		logic [31:0] d;
		logic        e;
		wr(8'h08, 32'h7fff);
		wr(8'h0c, 32'h8000);
		wr(8'h10, 32'h3);
		`CHK(aout.first, 16'h7fff)
		`CHK(aout.second, 16'h8000)
		wr(8'h08, 32'h1234);
		wr(8'h10, 32'h1);
		`CHK(aout.first, 16'h1234)
		`CHK(aout.second, 16'h8000)
		host_u.xfer(1'b0, 8'h24, 32'h0, d, e);
		`CHK(d, 32'h8000_1234)
	endtask
	task automatic t_fire;
		logic exp;
		for (int m = 0; m < 8; m++)
		begin
			exp = (m >= 3 && m <= 5);
			host_u.fire(m[2:0]);
			@(negedge clk_sys);
			`CHK(track_active, exp)
		end
		wr(8'h20, 32'h3);
		`CHK(track_active, 1'b0)
		wr(8'h20, 32'h0);
	endtask
	task automatic t_vel;
		wr(8'h14, 32'h5000_0000);
		wr(8'h18, 32'd16);
		wr(8'h1c, 32'h1);
		@(posedge clk_sys) meas_vel <= 24'sd2;
		host_u.fire(3'h4);
		settle;
		`CHK(aout.first, 16'h0a00)
		@(posedge clk_sys) meas_vel <= 24'sd20;
		settle;
		`CHK(aout.first, 16'h5000)
		@(posedge clk_sys) meas_vel <= 24'sd0;
		settle;
		`CHK(aout.first, 16'h0000)
		wr(8'h20, 32'h0);
		@(posedge clk_sys) meas_vel <= 24'sd16;
		settle;
		`CHK(aout.first, 16'h0000)
	endtask
	task automatic t_pos;
		logic [31:0] d;
		logic        e;
		@(posedge clk_sys) meas_pos <= 24'sd100;
		wr(8'h14, 32'h3000_1000);
		wr(8'h18, 32'd250);
		wr(8'h1c, 32'h7);
		host_u.fire(3'h5);
		// First update only: an origin taken late would show a step here
		repeat (48) @(posedge clk_sys);
		@(negedge clk_sys);
		`CHK(aout.second, 16'h1000)
		@(posedge clk_sys) meas_pos <= 24'sd105;
		settle;
		`CHK(aout.second, 16'h10a3)
		wr(8'h1c, 32'h2);
		host_u.xfer(1'b0, 8'h1c, 32'h0, d, e);
		`CHK(d[3:0], 4'hc)
		wr(8'h20, 32'h0);
	endtask
	initial
	begin
		do_reset;
		t_group;
		do_reset;
		t_lines;
		t_fixed;
		t_fire;
		t_vel;
		t_pos;
		end_of_test;
	end
endmodule
